// ===== src/eepsl_pkg.sv
// constants, types and layouts of the serial eeprom slave front end
// assumes a 50 MHz system clock and a bus clock of at most 1 MHz

package eepsl_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 20;
  localparam int unsigned T_WR_MS       = 5;
  localparam int unsigned WR_CYCLES     =
    (T_WR_MS * 1000000 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // ----------------------------------------------------------------
  // array organisation
  // ----------------------------------------------------------------
  localparam int unsigned N_PAGES    = 512;
  localparam int unsigned PAGE_W     = 6;
  localparam int unsigned ADDR_W     = $clog2(N_PAGES) + PAGE_W;
  localparam int unsigned BYTE_W     = 8;
  localparam int unsigned FIFO_W     = 1 + ADDR_W + BYTE_W;
  localparam int unsigned FIFO_DEPTH = 32;
  localparam int unsigned LOCK_BIT   = 10;

  // ----------------------------------------------------------------
  // select code and bit counting
  // ----------------------------------------------------------------
  localparam logic [3:0] TYPE_MEM = 4'ha;
  localparam logic [3:0] TYPE_ID  = 4'hb;
  localparam logic [3:0] BIT_LAST = 4'h7;
  localparam logic [3:0] BIT_ACK  = 4'h8;

  // ----------------------------------------------------------------
  // synchronised pins
  // ----------------------------------------------------------------
  localparam int unsigned N_PINS  = 6;
  localparam int unsigned P_SCL   = 0;
  localparam int unsigned P_SDA   = 1;
  localparam int unsigned P_STRAP = 2;
  localparam int unsigned P_WP    = 5;
  localparam int unsigned STRAP_W = 3;
  localparam logic [5:0]  PIN_RST = 6'h03;

  typedef enum logic [2:0] {
    S_IDLE, S_DEVSEL, S_ADDR_HI, S_ADDR_LO, S_WDATA, S_RDATA, S_WCYC
  } eepsl_state_e;

endpackage : eepsl_pkg

// ===== src/eepsl_stream_if.sv
// valid/ready word stream between the slave core and its fifo
// assumes both ends run on the same clock
`timescale 1ns/1ps

interface eepsl_stream_if #(
  parameter int unsigned W = 8
);
  logic         valid;
  logic         ready;
  logic [W-1:0] data;

  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface : eepsl_stream_if

// ===== src/eepsl_fifo.sv
// flip-flop fifo with valid/ready on both sides
// assumes one clock and a synchronous active-low reset
`timescale 1ns/1ps

module eepsl_fifo #(
  parameter int unsigned W     = 8,
  parameter int unsigned DEPTH = 32
) (
  // clock and reset
  input  wire logic      i_clk,
  input  wire logic      i_rst_n,
  // streams
  eepsl_stream_if.snk    in_if,
  eepsl_stream_if.src    out_if
);

  localparam int unsigned PW = $clog2(DEPTH);

  logic [W-1:0] mem_r [DEPTH];
  logic [PW:0]  wp_r;
  logic [PW:0]  rp_r;
  logic         full;
  logic         empty;
  logic         push;
  logic         pop;

  // ----------------------------------------------------------------
  // status
  // ----------------------------------------------------------------
  assign empty = (wp_r == rp_r);
  assign full  = (wp_r[PW] != rp_r[PW]) &&
                 (wp_r[PW-1:0] == rp_r[PW-1:0]);
  assign push  = in_if.valid && !full;
  assign pop   = out_if.ready && !empty;

  assign in_if.ready  = !full;
  assign out_if.valid = !empty;
  assign out_if.data  = mem_r[rp_r[PW-1:0]];

  // ----------------------------------------------------------------
  // pointers and storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wp_r <= '0;
      rp_r <= '0;
    end else begin
      if (push) wp_r <= wp_r + 1'b1;
      if (pop) rp_r <= rp_r + 1'b1;
    end
  end

  always_ff @(posedge i_clk) begin
    if (push) mem_r[wp_r[PW-1:0]] <= in_if.data;
  end

endmodule : eepsl_fifo

// ===== src/eepsl_top.sv
// serial eeprom slave front end: bus decode, ack, write queue
// assumes an external array behind the write and read ports
`timescale 1ns/1ps

module eepsl_top #(
  parameter int unsigned WR_CYCLES = eepsl_pkg::WR_CYCLES
) (
  // system clock and reset
  input  wire logic                        i_clk,
  input  wire logic                        i_rst_n,
  // serial bus
  input  wire logic                        i_scl,
  input  wire logic                        i_sda_i,
  output wire logic                        o_sda_o,
  output wire logic                        o_sda_oe,
  // straps
  input  wire logic                        i_chip_sel_strap_2,
  input  wire logic                        i_chip_sel_strap_1,
  input  wire logic                        i_chip_sel_strap_0,
  input  wire logic                        i_write_protect_in,
  // array write port
  output wire logic                        o_wr_valid,
  input  wire logic                        i_wr_ready,
  output wire logic                        o_wr_id,
  output wire logic [eepsl_pkg::ADDR_W-1:0] o_wr_addr,
  output wire logic [eepsl_pkg::BYTE_W-1:0] o_wr_data,
  // array read port
  output wire logic                        o_rd_en,
  output wire logic                        o_rd_id,
  output wire logic [eepsl_pkg::ADDR_W-1:0] o_rd_addr,
  input  wire logic [eepsl_pkg::BYTE_W-1:0] i_rd_data,
  // status
  output wire logic                        o_busy,
  output wire logic                        o_id_locked
);

  localparam int unsigned AW = eepsl_pkg::ADDR_W;
  localparam int unsigned BW = eepsl_pkg::BYTE_W;
  localparam int unsigned PW = eepsl_pkg::PAGE_W;
  localparam int unsigned NP = eepsl_pkg::N_PINS;

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic [NP-1:0] pin_raw;
  logic [NP-1:0] sy1_r;
  logic [NP-1:0] sy2_r;
  logic [NP-1:0] sy3_r;
  logic [NP-1:0] pin_q_r;

  // open straps and open protect pin are pulled to zero at the pad
  assign pin_raw = {i_write_protect_in,
                    i_chip_sel_strap_2,
                    i_chip_sel_strap_1,
                    i_chip_sel_strap_0,
                    i_sda_i,
                    i_scl};

  genvar g;
  generate
    for (g = 0; g < NP; g++) begin : g_sync
      always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
          sy1_r[g]   <= eepsl_pkg::PIN_RST[g];
          sy2_r[g]   <= eepsl_pkg::PIN_RST[g];
          sy3_r[g]   <= eepsl_pkg::PIN_RST[g];
          pin_q_r[g] <= eepsl_pkg::PIN_RST[g];
        end else begin
          sy1_r[g] <= pin_raw[g];
          sy2_r[g] <= sy1_r[g];
          sy3_r[g] <= sy2_r[g];
          if (sy2_r[g] == sy3_r[g]) pin_q_r[g] <= sy3_r[g];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // bus events
  // ----------------------------------------------------------------
  logic                             scl_q;
  logic                             sda_q;
  logic                             scl_hi;
  logic                             scl_rise;
  logic                             scl_fall;
  logic                             sda_rise;
  logic                             sda_fall;
  logic                             start_ev;
  logic                             stop_ev;
  logic [eepsl_pkg::STRAP_W-1:0]    strap_q;
  logic                             wp_q;

  assign scl_q    = pin_q_r[eepsl_pkg::P_SCL];
  assign sda_q    = pin_q_r[eepsl_pkg::P_SDA];
  assign strap_q  = pin_q_r[eepsl_pkg::P_STRAP +: eepsl_pkg::STRAP_W];
  assign wp_q     = pin_q_r[eepsl_pkg::P_WP];
  assign scl_rise = !scl_q && sy2_r[eepsl_pkg::P_SCL] &&
                    sy3_r[eepsl_pkg::P_SCL];
  assign scl_fall = scl_q && !sy2_r[eepsl_pkg::P_SCL] &&
                    !sy3_r[eepsl_pkg::P_SCL];
  assign sda_rise = !sda_q && sy2_r[eepsl_pkg::P_SDA] &&
                    sy3_r[eepsl_pkg::P_SDA];
  assign sda_fall = sda_q && !sy2_r[eepsl_pkg::P_SDA] &&
                    !sy3_r[eepsl_pkg::P_SDA];
  assign scl_hi   = scl_q && !scl_fall;
  assign start_ev = scl_hi && sda_fall;
  assign stop_ev  = scl_hi && sda_rise;

  // ----------------------------------------------------------------
  // link clock domain
  // ----------------------------------------------------------------
  logic [BW-1:0] lnk_sh_r;
  logic          lnk_low_r;
  logic          drv_r;
  logic          bus_en_r;

  // data sampled on the bus clock rise
  always_ff @(posedge i_scl) begin
    lnk_sh_r <= {lnk_sh_r[BW-2:0], i_sda_i};
  end

  // drive changes only after the bus clock falls
  always_ff @(negedge i_scl) begin
    lnk_low_r <= drv_r;
  end

  assign o_sda_o  = 1'b0;
  assign o_sda_oe = lnk_low_r && bus_en_r;

  // ----------------------------------------------------------------
  // write queue
  // ----------------------------------------------------------------
  eepsl_stream_if #(.W(eepsl_pkg::FIFO_W)) q_in  ();
  eepsl_stream_if #(.W(eepsl_pkg::FIFO_W)) q_out ();

  eepsl_fifo #(
    .W     (eepsl_pkg::FIFO_W),
    .DEPTH (eepsl_pkg::FIFO_DEPTH)
  ) u_fifo (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .in_if   (q_in),
    .out_if  (q_out)
  );

  assign q_out.ready = i_wr_ready;
  assign o_wr_valid  = q_out.valid;
  assign o_wr_id     = q_out.data[AW+BW];
  assign o_wr_addr   = q_out.data[BW +: AW];
  assign o_wr_data   = q_out.data[BW-1:0];

  // ----------------------------------------------------------------
  // core state
  // ----------------------------------------------------------------
  eepsl_pkg::eepsl_state_e state_r;
  eepsl_pkg::eepsl_state_e state_nxt;
  logic [3:0]              bit_r;
  logic [3:0]              bit_nxt;
  logic                    ack_r;
  logic                    ack_nxt;
  logic                    id_r;
  logic                    id_nxt;
  logic                    rw_r;
  logic                    rw_nxt;
  logic [AW-1:0]           addr_r;
  logic [AW-1:0]           addr_nxt;
  logic [BW-1:0]           tx_r;
  logic [BW-1:0]           tx_nxt;
  logic                    wrote_r;
  logic                    wrote_nxt;
  logic                    lock_sel_r;
  logic                    lock_sel_nxt;
  logic                    lock_pend_r;
  logic                    lock_pend_nxt;
  logic                    lock_r;
  logic                    lock_nxt;
  logic [31:0]             cnt_r;
  logic [31:0]             cnt_nxt;
  logic                    rd_pend_r;
  logic                    drv_nxt;
  logic                    rd_en;
  logic                    push;

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  logic          type_ok;
  logic          dev_hit;
  logic          is_rx;
  logic          sel_id;
  logic          wr_ok;
  logic          at_last;
  logic          at_ack;
  logic [AW-1:0] addr_inc;
  logic [AW-1:0] page_inc;

  assign type_ok  = (lnk_sh_r[7:4] == eepsl_pkg::TYPE_MEM) ||
                    (lnk_sh_r[7:4] == eepsl_pkg::TYPE_ID);
  assign dev_hit  = type_ok && (lnk_sh_r[3:1] == strap_q);
  assign is_rx    = (state_r == eepsl_pkg::S_DEVSEL) ||
                    (state_r == eepsl_pkg::S_ADDR_HI) ||
                    (state_r == eepsl_pkg::S_ADDR_LO) ||
                    (state_r == eepsl_pkg::S_WDATA);
  // page select of the select byte being decoded, else of the last one
  assign sel_id   = (state_r == eepsl_pkg::S_DEVSEL) ? lnk_sh_r[4] : id_r;
  // protect high, full queue or locked page refuse the data byte
  assign wr_ok    = !wp_q && q_in.ready &&
                    !(id_r && lock_r);
  assign at_last  = scl_rise && (bit_r == eepsl_pkg::BIT_LAST);
  assign at_ack   = scl_rise && (bit_r == eepsl_pkg::BIT_ACK);
  assign addr_inc = sel_id ?
                    {addr_r[AW-1:PW], addr_r[PW-1:0] + 1'b1} :
                    addr_r + 1'b1;
  // writes roll over inside one 64-byte page
  assign page_inc = {addr_r[AW-1:PW], addr_r[PW-1:0] + 1'b1};

  assign rd_en = (at_last && (state_r == eepsl_pkg::S_DEVSEL) &&
                  dev_hit && lnk_sh_r[0]) ||
                 (at_ack && (state_r == eepsl_pkg::S_RDATA) &&
                  !sda_q);
  assign push  = at_last && (state_r == eepsl_pkg::S_WDATA) &&
                 wr_ok && !(id_r && lock_sel_r);

  assign q_in.valid = push;
  assign q_in.data  = {id_r, addr_r, lnk_sh_r};
  assign o_rd_en    = rd_en;
  assign o_rd_id    = sel_id;
  assign o_rd_addr  = addr_r;
  assign o_busy     = (state_r == eepsl_pkg::S_WCYC);
  assign o_id_locked = lock_r;

  // receiver acks in the ninth slot; transmitter shifts msb first
  assign drv_nxt = (is_rx && (bit_r == eepsl_pkg::BIT_ACK) && ack_r) ||
                   ((state_r == eepsl_pkg::S_RDATA) &&
                    (bit_r < eepsl_pkg::BIT_ACK) &&
                    !tx_r[BW-1]);

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt     = state_r;
    bit_nxt       = bit_r;
    ack_nxt       = ack_r;
    id_nxt        = id_r;
    rw_nxt        = rw_r;
    addr_nxt      = addr_r;
    tx_nxt        = tx_r;
    wrote_nxt     = wrote_r;
    lock_sel_nxt  = lock_sel_r;
    lock_pend_nxt = lock_pend_r;
    lock_nxt      = lock_r;
    cnt_nxt       = cnt_r;
    if (rd_pend_r) begin
      tx_nxt = i_rd_data;
    end
    if (rd_en) begin
      addr_nxt = addr_inc;
    end
    if (state_r == eepsl_pkg::S_WCYC) begin
      // start conditions are not watched during the write cycle
      if (cnt_r != '0) begin
        cnt_nxt = cnt_r - 1'b1;
      end else if (!q_out.valid) begin
        state_nxt = eepsl_pkg::S_IDLE;
      end
    end else if (start_ev) begin
      state_nxt = eepsl_pkg::S_DEVSEL;
      bit_nxt   = '0;
      ack_nxt   = 1'b0;
    end else if (stop_ev) begin
      if (wrote_r || lock_pend_r) begin
        state_nxt = eepsl_pkg::S_WCYC;
        cnt_nxt   = 32'(WR_CYCLES);
        lock_nxt  = lock_r || lock_pend_r;
      end else begin
        state_nxt = eepsl_pkg::S_IDLE;
      end
      wrote_nxt     = 1'b0;
      lock_pend_nxt = 1'b0;
    end else if (scl_rise && (state_r != eepsl_pkg::S_IDLE)) begin
      bit_nxt = (bit_r == eepsl_pkg::BIT_ACK) ? '0 : bit_r + 1'b1;
      if ((state_r == eepsl_pkg::S_RDATA) &&
          (bit_r < eepsl_pkg::BIT_ACK)) begin
        tx_nxt = {tx_r[BW-2:0], 1'b0};
      end
      if (bit_r == eepsl_pkg::BIT_LAST) begin
        unique case (state_r)
          eepsl_pkg::S_DEVSEL: begin
            ack_nxt = dev_hit;
            id_nxt  = lnk_sh_r[4];
            rw_nxt  = lnk_sh_r[0];
          end
          eepsl_pkg::S_ADDR_HI: begin
            ack_nxt      = 1'b1;
            addr_nxt     = {lnk_sh_r[AW-BW-1:0], addr_r[BW-1:0]};
            lock_sel_nxt = lnk_sh_r[eepsl_pkg::LOCK_BIT-BW];
          end
          eepsl_pkg::S_ADDR_LO: begin
            ack_nxt  = 1'b1;
            addr_nxt = {addr_r[AW-1:BW], lnk_sh_r};
          end
          eepsl_pkg::S_WDATA: begin
            ack_nxt = wr_ok;
            if (wr_ok && id_r && lock_sel_r) begin
              lock_pend_nxt = 1'b1;
            end else if (wr_ok) begin
              wrote_nxt = 1'b1;
              addr_nxt  = page_inc;
            end
          end
          default: begin
            ack_nxt = 1'b0;
          end
        endcase
      end
      if (bit_r == eepsl_pkg::BIT_ACK) begin
        if (state_r == eepsl_pkg::S_RDATA) begin
          if (sda_q) begin
            state_nxt = eepsl_pkg::S_IDLE;
          end
        end else if (!ack_r) begin
          state_nxt = eepsl_pkg::S_IDLE;
        end else begin
          unique case (state_r)
            eepsl_pkg::S_DEVSEL:
              state_nxt = rw_r ? eepsl_pkg::S_RDATA :
                                 eepsl_pkg::S_ADDR_HI;
            eepsl_pkg::S_ADDR_HI: state_nxt = eepsl_pkg::S_ADDR_LO;
            eepsl_pkg::S_ADDR_LO: state_nxt = eepsl_pkg::S_WDATA;
            default:              state_nxt = state_r;
          endcase
        end
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_r <= eepsl_pkg::S_IDLE;
      bit_r   <= '0;
      ack_r   <= 1'b0;
      id_r    <= 1'b0;
      rw_r    <= 1'b0;
    end else begin
      state_r <= state_nxt;
      bit_r   <= bit_nxt;
      ack_r   <= ack_nxt;
      id_r    <= id_nxt;
      rw_r    <= rw_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      addr_r     <= '0;
      tx_r       <= '0;
      rd_pend_r  <= 1'b0;
      cnt_r      <= '0;
    end else begin
      addr_r     <= addr_nxt;
      tx_r       <= tx_nxt;
      rd_pend_r  <= rd_en;
      cnt_r      <= cnt_nxt;
    end
  end

  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      wrote_r     <= 1'b0;
      lock_sel_r  <= 1'b0;
      lock_pend_r <= 1'b0;
      lock_r      <= 1'b0;
    end else begin
      wrote_r     <= wrote_nxt;
      lock_sel_r  <= lock_sel_nxt;
      lock_pend_r <= lock_pend_nxt;
      lock_r      <= lock_nxt;
    end
  end

  // drive request and pin enable, stable before the bus clock falls
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      drv_r    <= 1'b0;
      bus_en_r <= 1'b0;
    end else begin
      drv_r    <= drv_nxt;
      bus_en_r <= (state_nxt != eepsl_pkg::S_IDLE) &&
                  (state_nxt != eepsl_pkg::S_WCYC);
    end
  end

endmodule : eepsl_top

// ===== test/eepsl_chk.sv
// assertions on the pins of the eeprom slave front end
// assumes binding into eepsl_top, all checks on i_clk
`timescale 1ns/1ps

module eepsl_chk #(
  parameter int unsigned WR_CYCLES = 50
) (
  // clock and reset
  input wire logic                          i_clk,
  input wire logic                          i_rst_n,
  // bus and straps
  input wire logic                          i_scl,
  input wire logic                          i_write_protect_in,
  input wire logic                          o_sda_o,
  input wire logic                          o_sda_oe,
  // array ports and status
  input wire logic                          o_wr_valid,
  input wire logic                          i_wr_ready,
  input wire logic                          o_wr_id,
  input wire logic [eepsl_pkg::ADDR_W-1:0]  o_wr_addr,
  input wire logic [eepsl_pkg::BYTE_W-1:0]  o_wr_data,
  input wire logic                          o_rd_en,
  input wire logic                          o_busy,
  input wire logic                          o_id_locked
);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  property p_od; !o_sda_o; endproperty
  a_od: assert property (p_od)
    else $error("data pin driven high");
  property p_oe_rise; $rose(o_sda_oe) |-> !i_scl; endproperty
  a_oe_rise: assert property (p_oe_rise)
    else $error("data pull began with clock high");
  property p_rd_scl; o_rd_en |-> i_scl; endproperty
  a_rd_scl: assert property (p_rd_scl)
    else $error("read strobe outside clock high");
  property p_rd_pulse; o_rd_en |=> !o_rd_en; endproperty
  a_rd_pulse: assert property (p_rd_pulse)
    else $error("read strobe longer than one cycle");
  property p_busy_quiet; o_busy && $past(o_busy) |-> !o_sda_oe;
  endproperty
  a_busy_quiet: assert property (p_busy_quiet)
    else $error("bus answered during write cycle");
  property p_busy_rd; o_busy |-> !o_rd_en; endproperty
  a_busy_rd: assert property (p_busy_rd)
    else $error("array read during write cycle");
  property p_wp; i_write_protect_in [*8] |-> !$rose(o_wr_valid);
  endproperty
  a_wp: assert property (p_wp)
    else $error("write queued while protected");
  property p_hold;
    o_wr_valid && !i_wr_ready |=>
      o_wr_valid && $stable({o_wr_id, o_wr_addr, o_wr_data});
  endproperty
  a_hold: assert property (p_hold)
    else $error("queued write changed while stalled");
  property p_lock; o_id_locked |=> o_id_locked; endproperty
  a_lock: assert property (p_lock)
    else $error("lock flag dropped");
endmodule : eepsl_chk

bind eepsl_top eepsl_chk #(.WR_CYCLES(WR_CYCLES)) eepsl_chk_i (
  .i_clk(i_clk), .i_rst_n(i_rst_n), .i_scl(i_scl),
  .i_write_protect_in(i_write_protect_in), .o_sda_o(o_sda_o),
  .o_sda_oe(o_sda_oe), .o_wr_valid(o_wr_valid),
  .i_wr_ready(i_wr_ready), .o_wr_id(o_wr_id), .o_wr_addr(o_wr_addr),
  .o_wr_data(o_wr_data), .o_rd_en(o_rd_en), .o_busy(o_busy),
  .o_id_locked(o_id_locked)
);

// ===== test/eepsl_master.sv
// two-wire bus master model: serial clock and data pull-down
// assumes a pull-up on the data wire, its level fed back on i_sda
`timescale 1ns/1ps

module eepsl_master (
  // clock
  input  wire logic i_clk,
  // bus
  input  wire logic i_sda,
  output logic      o_scl,
  output logic      o_sda_pull
);
  // ----------------------------------------------------------------
  // bus cycles, clock stands high between frames
  // ----------------------------------------------------------------
  initial begin
    o_scl      = 1'b1;
    o_sda_pull = 1'b0;
  end

  // half period of 25 clk keeps the bus at 1 MHz
  task automatic hp;
    repeat (25) @(negedge i_clk);
  endtask : hp

  task automatic bit1(input logic b, output logic s);
    o_sda_pull = ~b;
    hp();
    o_scl = 1'b1;
    hp();
    s = i_sda;
    o_scl = 1'b0;
  endtask : bit1

  task automatic start;
    o_sda_pull = 1'b0;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_pull = 1'b1;
    hp();
    o_scl = 1'b0;
  endtask : start

  task automatic stop;
    o_sda_pull = 1'b1;
    hp();
    o_scl = 1'b1;
    hp();
    o_sda_pull = 1'b0;
    hp();
  endtask : stop

  // byte out msb first, data released for the ninth bit
  task automatic wb(input logic [7:0] b, output logic a);
    logic s;
    for (int i = 7; i >= 0; i--) bit1(b[i], s);
    bit1(1'b1, s);
    a = ~s;
  endtask : wb

  // byte in, pulled low on the ninth bit unless last
  task automatic rb(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--) bit1(1'b1, d[i]);
    bit1(last, s);
  endtask : rb
endmodule : eepsl_master

// ===== test/eepsl_top_tb.sv
// self-checking bench for the eeprom slave front end
// assumes eepsl_master as bus master, bench acts as the array
`timescale 1ns/1ps
`define CHK(a, e) begin \
  tests_run++; \
  if ((a) !== (e)) begin \
    miscompares++; \
    $display("BAD t=%0t got=%h exp=%h", $time, a, e); \
  end \
end

module eepsl_top_tb;
  localparam int unsigned WRC = 50;
  logic        clk, rst_n, scl, pull, sda, sda_o, sda_oe, wp;
  logic        wr_valid, wr_ready, wr_id, rd_en, rd_id, busy, locked;
  logic [2:0]  strap;
  logic [14:0] wr_addr, rd_addr;
  logic [7:0]  wr_data, rd_data, d;
  int          miscompares = 0;
  int          tests_run = 0;

  assign sda = ~(pull | sda_oe);
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  initial rd_data = 8'h00;
  always @(negedge clk) if (rd_en) rd_data <= {rd_id, rd_addr[6:0]} ^ 8'h5a;

  eepsl_master eepsl_master_i (.i_clk(clk), .i_sda(sda), .o_scl(scl),
    .o_sda_pull(pull));
  eepsl_top #(.WR_CYCLES(WRC)) eepsl_top_i (.i_clk(clk), .i_rst_n(rst_n),
    .i_scl(scl), .i_sda_i(sda), .o_sda_o(sda_o), .o_sda_oe(sda_oe),
    .i_chip_sel_strap_2(strap[2]), .i_chip_sel_strap_1(strap[1]),
    .i_chip_sel_strap_0(strap[0]), .i_write_protect_in(wp),
    .o_wr_valid(wr_valid), .i_wr_ready(wr_ready), .o_wr_id(wr_id),
    .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_en(rd_en),
    .o_rd_id(rd_id), .o_rd_addr(rd_addr), .i_rd_data(rd_data),
    .o_busy(busy), .o_id_locked(locked));

  // ----------------------------------------------------------------
  // helpers and scenarios
  // ----------------------------------------------------------------
  task automatic sx(input logic [7:0] b, input logic e);
    logic a;
    eepsl_master_i.wb(b, a);
    `CHK(a, e)
  endtask : sx

  task automatic wbz;
    for (int i = 0; i < 4000 && busy; i++) @(negedge clk);
    `CHK(busy, 1'b0)
  endtask : wbz

  task automatic t_sel;
    localparam logic [47:0] SELS = 48'haaba_a0a8_ca2a;
    strap = 3'b101;
    repeat (8) @(negedge clk);
    for (int j = 0; j < 6; j++) begin
      eepsl_master_i.start();
      sx(SELS[47-8*j -: 8], j < 2);
      eepsl_master_i.stop();
    end
    strap = 3'b000;
    repeat (8) @(negedge clk);
  endtask : t_sel

  task automatic t_write;
    eepsl_master_i.start();
    sx(8'ha0, 1'b1);
    sx(8'h05, 1'b1);
    sx(8'h30, 1'b1);
    for (int k = 0; k < 33; k++) sx(8'(k), k < 32);
    eepsl_master_i.stop();
    eepsl_master_i.start();
    sx(8'ha0, 1'b0);
    eepsl_master_i.stop();
    `CHK(busy, 1'b1)
    for (int k = 0; k < 32; k++) begin
      `CHK({wr_valid, wr_id, wr_addr, wr_data},
           {2'b10, 9'h014, 6'(6'h30 + k), 8'(k)})
      wr_ready = 1'b1;
      @(negedge clk);
      wr_ready = 1'b0;
      @(negedge clk);
    end
    `CHK(wr_valid, 1'b0)
    wbz();
  endtask : t_write

  task automatic t_wp;
    wp = 1'b1;
    repeat (8) @(negedge clk);
    eepsl_master_i.start();
    sx(8'ha0, 1'b1);
    sx(8'h01, 1'b1);
    sx(8'h40, 1'b1);
    sx(8'h55, 1'b0);
    eepsl_master_i.stop();
    `CHK(wr_valid, 1'b0)
    wbz();
    wp = 1'b0;
  endtask : t_wp

  task automatic t_read;
    eepsl_master_i.start();
    sx(8'ha0, 1'b1);
    sx(8'h01, 1'b1);
    sx(8'h10, 1'b1);
    eepsl_master_i.start();
    sx(8'ha1, 1'b1);
    eepsl_master_i.rb(1'b0, d);
    `CHK(d, 8'h10 ^ 8'h5a)
    eepsl_master_i.rb(1'b1, d);
    `CHK(d, 8'h11 ^ 8'h5a)
    eepsl_master_i.stop();
    eepsl_master_i.start();
    sx(8'hb1, 1'b1);
    eepsl_master_i.rb(1'b1, d);
    `CHK(d, 8'h92 ^ 8'h5a)
    eepsl_master_i.stop();
  endtask : t_read

  task automatic t_id;
    eepsl_master_i.start();
    sx(8'hb0, 1'b1);
    sx(8'h00, 1'b1);
    sx(8'h05, 1'b1);
    sx(8'h3c, 1'b1);
    eepsl_master_i.stop();
    `CHK({wr_valid, wr_id, wr_addr[5:0], wr_data}, {2'b11, 6'h05, 8'h3c})
    wr_ready = 1'b1;
    wbz();
    eepsl_master_i.start();
    sx(8'hb0, 1'b1);
    sx(8'h04, 1'b1);
    sx(8'h00, 1'b1);
    sx(8'h02, 1'b1);
    eepsl_master_i.stop();
    wbz();
    `CHK(locked, 1'b1)
    eepsl_master_i.start();
    sx(8'hb0, 1'b1);
    sx(8'h00, 1'b1);
    sx(8'h00, 1'b1);
    sx(8'h77, 1'b0);
    eepsl_master_i.stop();
  endtask : t_id

  task automatic summarize;
    if (miscompares == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : summarize

  initial begin
    #1_000_000;
    miscompares++;
    summarize();
  end

  initial begin
    rst_n = 1'b0;
    strap = 3'b000;
    wp = 1'b0;
    wr_ready = 1'b0;
    repeat (5) @(negedge clk);
    rst_n = 1'b1;
    repeat (5) @(negedge clk);
    t_sel();
    t_write();
    t_wp();
    t_read();
    t_id();
    summarize();
  end
endmodule : eepsl_top_tb
